/* File: hw/rsrb_regs.svh */
/*
 * Offsets, field positions, reset values and constants of the shared
 * register page.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef RSRB_REGS_SVH
`define RSRB_REGS_SVH

// Overview of operation
// - upper nibble offset 0 reports address strap
// - offset 2 selects 25/125/312.5 MHz reference
// - offset 4 bit 6 resets shared page
// - offset 4 bit 5 resets loader controller
// - offset 4 bit 3 disables lock sequencer
// - offset 4 bit 7 picks divided clock out
// - offset 5 bit 6 triggers CRC check
// - offset 5 bit 4 flags EEPROM load done
// - offset 5 bits 3:0 limit concurrent locks
// - offset 8 shows quads zero and one irqs
// - offset 9 shows quads two and three irqs
// - shared page reachable only with page bit zero
// - self-clearing bits return to zero alone

// ****************************************************************
// register offsets
// ****************************************************************
`define RSRB_OFS_ADDR 8'h00
`define RSRB_OFS_ID 8'h01
`define RSRB_OFS_REFSEL 8'h02
`define RSRB_OFS_RSV3 8'h03
`define RSRB_OFS_CTRL 8'h04
`define RSRB_OFS_LIMIT 8'h05
`define RSRB_OFS_RSV6 8'h06
`define RSRB_OFS_RSV7 8'h07
`define RSRB_OFS_IRQ_LO 8'h08
`define RSRB_OFS_IRQ_HI 8'h09

// ****************************************************************
// field positions
// ****************************************************************
`define RSRB_REFSEL_HI 6
`define RSRB_REFSEL_LO 5
`define RSRB_DIVCLK_BIT 7
`define RSRB_PAGE_RST_BIT 6
`define RSRB_LOADER_RST_BIT 5
`define RSRB_LOCK_DIS_BIT 3
`define RSRB_CRC_BIT 6
`define RSRB_EEDONE_BIT 4
`define RSRB_LIMIT_HI 3

// ****************************************************************
// reset values and constants
// ****************************************************************
`define RSRB_ADDR_BASE 7'h18
`define RSRB_REFSEL_RST 2'h0
`define RSRB_REFSEL_BAD 2'h3
`define RSRB_LIMIT_RST 4'h8
`define RSRB_CTRL_RSV_LOW 3'h1
`define RSRB_EEDONE_RST 1'b1

`endif

/* File: hw/rsrb_pkg.sv */
/*
 * Types of the shared register page.
 * Assumes rsrb_regs.svh is on the include path.
 */
`include "rsrb_regs.svh"

package rsrb_pkg;

    // reference input frequency codes; code 2'h3 is reserved
    typedef enum logic [1:0]
    {
        RSRB_REF_25M = 2'h0,
        RSRB_REF_125M = 2'h1,
        RSRB_REF_312M = 2'h2
    } rsrb_ref_freq_t;

    typedef logic [7:0] rsrb_byte_t;

endpackage

/* File: hw/rsrb_sc_bit.sv */
/*
 * Self-clearing control bit: one write of one gives a one-cycle level.
 * Assumes set_req is a single-cycle write strobe from the register port.
 */
`timescale 1ns/1ps

module rsrb_sc_bit
    import rsrb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic set_req,
    output logic bit_q
);

    logic bit_r;

    // ****************************************************************
    // set by write, clears itself next edge
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            bit_r <= 1'b0;
        else
            bit_r <= set_req;
    end

    assign bit_q = bit_r;

    clears_alone_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        bit_r && !set_req |=> !bit_r)
        else $error("self-clearing bit did not clear");

endmodule

/* File: hw/rsrb_strap_cap.sv */
/*
 * Captures the address strap once, on the first edge after reset release.
 * Assumes the strap pins are stable around the end of reset.
 */
`timescale 1ns/1ps

module rsrb_strap_cap
    import rsrb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [3:0] strap_in,
    output logic [3:0] strap_q,
    output logic done_q
);

    logic [3:0] strap_r;
    logic done_r;

    // ****************************************************************
    // one-shot capture after release
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            strap_r <= 4'h0;
            done_r <= 1'b0;
        end
        else if (!done_r)
        begin
            strap_r <= strap_in;
            done_r <= 1'b1;
        end
    end

    assign strap_q = strap_r;
    assign done_q = done_r;

endmodule

/* File: hw/rsrb_shared_page.sv */
/*
 * Shared register page of the sixteen-channel retimer: strap address,
 * identity, reference selection, soft resets, lock control, CRC trigger,
 * EEPROM-done flag and per-channel interrupt summary.
 * Assumes the serial target front end has turned bus bytes into one-cycle
 * read and write strobes with an offset, and supplies the page-select bit.
 */
`timescale 1ns/1ps
`include "rsrb_regs.svh"

module rsrb_shared_page
    import rsrb_pkg::*;
#(
    parameter logic [2:0] SILICON_REV = 3'h1, // arbitrary value
    parameter logic [4:0] PART_ID = 5'h0A // arbitrary value
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic page_sel_channel,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic [3:0] strap_address_bits,
    input wire logic eeprom_load_done,
    input wire logic [15:0] channel_irq_flag,
    output logic [6:0] bus_target_addr,
    output rsrb_ref_freq_t ref_frequency_choice,
    output logic divided_clock_out_choice,
    output logic lock_sequencer_disable,
    output logic [3:0] concurrent_lock_limit,
    output logic crc_check_start,
    output logic loader_controller_reset
);

    logic wr_ok;
    logic rd_ok;
    logic wr_refsel;
    logic wr_ctrl;
    logic wr_limit;
    logic page_rst_set;
    logic loader_rst_set;
    logic page_rst_q;
    logic loader_rst_q;
    logic [3:0] strap_q;
    logic strap_done;
    logic [6:0] addr_r;
    rsrb_ref_freq_t ref_sel_r;
    logic divclk_r;
    logic lock_dis_r;
    logic crc_en_r;
    logic crc_start_r;
    logic eedone_r;
    logic [3:0] limit_r;
    rsrb_byte_t rd_word;
    rsrb_byte_t rd_data_r;
    logic rd_valid_r;

    // ****************************************************************
    // access decode
    // ****************************************************************
    assign wr_ok = wr_en && !page_sel_channel;
    assign rd_ok = rd_en && !page_sel_channel;
    assign wr_refsel = wr_ok && (reg_addr == `RSRB_OFS_REFSEL);
    assign wr_ctrl = wr_ok && (reg_addr == `RSRB_OFS_CTRL);
    assign wr_limit = wr_ok && (reg_addr == `RSRB_OFS_LIMIT);
    assign page_rst_set = wr_ctrl && wr_data[`RSRB_PAGE_RST_BIT];
    assign loader_rst_set = wr_ctrl && wr_data[`RSRB_LOADER_RST_BIT];

    // ****************************************************************
    // self-clearing resets
    // ****************************************************************
    rsrb_sc_bit u_page_rst
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .set_req(page_rst_set),
        .bit_q(page_rst_q)
    );

    rsrb_sc_bit u_loader_rst
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .set_req(loader_rst_set),
        .bit_q(loader_rst_q)
    );

    // ****************************************************************
    // strap address
    // ****************************************************************
    rsrb_strap_cap u_strap
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .strap_in(strap_address_bits),
        .strap_q(strap_q),
        .done_q(strap_done)
    );

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            addr_r <= `RSRB_ADDR_BASE;
        else
            addr_r <= `RSRB_ADDR_BASE + {3'h0, strap_q};
    end

    // ****************************************************************
    // reference frequency selection
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            ref_sel_r <= rsrb_ref_freq_t'(`RSRB_REFSEL_RST);
        else if (page_rst_q)
            ref_sel_r <= rsrb_ref_freq_t'(`RSRB_REFSEL_RST);
        else if (wr_refsel && (wr_data[`RSRB_REFSEL_HI:`RSRB_REFSEL_LO]
                 != `RSRB_REFSEL_BAD))
            ref_sel_r <= rsrb_ref_freq_t'(
                wr_data[`RSRB_REFSEL_HI:`RSRB_REFSEL_LO]);
    end

    // ****************************************************************
    // clock-out choice and lock sequencer control
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            divclk_r <= 1'b0;
            lock_dis_r <= 1'b0;
        end
        else if (page_rst_q)
        begin
            divclk_r <= 1'b0;
            lock_dis_r <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            divclk_r <= wr_data[`RSRB_DIVCLK_BIT];
            lock_dis_r <= wr_data[`RSRB_LOCK_DIS_BIT];
        end
    end

    // ****************************************************************
    // concurrent lock limit
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            limit_r <= `RSRB_LIMIT_RST;
        else if (page_rst_q)
            limit_r <= `RSRB_LIMIT_RST;
        else if (wr_limit)
            limit_r <= wr_data[`RSRB_LIMIT_HI:0];
    end

    // ****************************************************************
    // CRC trigger: start pulse on a written rising edge of the enable
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            crc_en_r <= 1'b0;
            crc_start_r <= 1'b0;
        end
        else if (page_rst_q)
        begin
            crc_en_r <= 1'b0;
            crc_start_r <= 1'b0;
        end
        else
        begin
            if (wr_limit)
                crc_en_r <= wr_data[`RSRB_CRC_BIT];
            crc_start_r <= wr_limit && wr_data[`RSRB_CRC_BIT]
                && !crc_en_r;
        end
    end

    // ****************************************************************
    // EEPROM load done: cleared by loader reset, set wins
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            eedone_r <= `RSRB_EEDONE_RST;
        else if (eeprom_load_done)
            eedone_r <= 1'b1;
        else if (loader_rst_q)
            eedone_r <= 1'b0;
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    always_comb
    begin
        rd_word = 8'h00;
        case (reg_addr)
            `RSRB_OFS_ADDR:
                rd_word = {strap_q, 4'h0};
            `RSRB_OFS_ID:
                rd_word = {SILICON_REV, PART_ID};
            `RSRB_OFS_REFSEL:
                rd_word = {1'b0, ref_sel_r, 5'h00};
            `RSRB_OFS_CTRL:
                rd_word = {divclk_r, page_rst_q, loader_rst_q, 1'b0,
                    lock_dis_r, `RSRB_CTRL_RSV_LOW};
            `RSRB_OFS_LIMIT:
                rd_word = {1'b0, crc_en_r, 1'b0, eedone_r, limit_r};
            `RSRB_OFS_IRQ_LO:
                rd_word = channel_irq_flag[7:0];
            `RSRB_OFS_IRQ_HI:
                rd_word = channel_irq_flag[15:8];
            default:
                rd_word = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            rd_data_r <= 8'h00;
        else if (rd_en)
            rd_data_r <= rd_ok ? rd_word : 8'h00;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            rd_valid_r <= 1'b0;
        else
            rd_valid_r <= rd_en;
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign bus_target_addr = addr_r;
    assign ref_frequency_choice = ref_sel_r;
    assign divided_clock_out_choice = divclk_r;
    assign lock_sequencer_disable = lock_dis_r;
    assign concurrent_lock_limit = limit_r;
    assign crc_check_start = crc_start_r;
    assign loader_controller_reset = loader_rst_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    strap_address_a: assert property (
        strap_done |=> bus_target_addr ==
            `RSRB_ADDR_BASE + {3'h0, $past(strap_q)})
        else $error("target address not base plus strap");

    refsel_legal_a: assert property (
        wr_refsel && !page_rst_q |=>
            ref_frequency_choice != `RSRB_REFSEL_BAD)
        else $error("reserved frequency code taken");

    page_reset_a: assert property (
        page_rst_set |=> page_rst_q ##1 (!page_rst_q
            && concurrent_lock_limit == `RSRB_LIMIT_RST
            && ref_frequency_choice == RSRB_REF_25M
            && !lock_sequencer_disable && !divided_clock_out_choice))
        else $error("shared page soft reset did not restore defaults");

    loader_pulse_a: assert property (
        loader_rst_set |=> loader_controller_reset
            ##1 (!loader_controller_reset || $past(loader_rst_set)))
        else $error("loader reset not a self-clearing pulse");

    lock_disable_a: assert property (
        wr_ctrl && !page_rst_q |=>
            lock_sequencer_disable == $past(wr_data[`RSRB_LOCK_DIS_BIT]))
        else $error("lock sequencer disable not written");

    divclk_choice_a: assert property (
        wr_ctrl && !page_rst_q |=>
            divided_clock_out_choice == $past(wr_data[`RSRB_DIVCLK_BIT]))
        else $error("clock-out choice not written");

    crc_trigger_a: assert property (
        wr_limit && wr_data[`RSRB_CRC_BIT] && !crc_en_r && !page_rst_q
            |=> crc_check_start ##1 !crc_check_start)
        else $error("CRC trigger pulse wrong");

    eeprom_done_a: assert property (
        eeprom_load_done |=> eedone_r)
        else $error("EEPROM done flag not set");

    lock_limit_a: assert property (
        wr_limit && !page_rst_q |=>
            concurrent_lock_limit == $past(wr_data[3:0]))
        else $error("lock limit not written");

    irq_low_a: assert property (
        rd_ok && reg_addr == `RSRB_OFS_IRQ_LO |=>
            rd_valid && rd_data == $past(channel_irq_flag[7:0]))
        else $error("low quad interrupt summary wrong");

    irq_high_a: assert property (
        rd_ok && reg_addr == `RSRB_OFS_IRQ_HI |=>
            rd_valid && rd_data == $past(channel_irq_flag[15:8]))
        else $error("high quad interrupt summary wrong");

    page_closed_a: assert property (
        rd_en && page_sel_channel |=> rd_valid && rd_data == 8'h00)
        else $error("shared page answered while channel page set");

    reserved_read_a: assert property (
        rd_ok && reg_addr == `RSRB_OFS_RSV3 |=> rd_data == 8'h00)
        else $error("reserved register not at default");

    soft_reset_c: cover property (page_rst_set ##2 !page_rst_q);
    crc_start_c: cover property (crc_check_start);
    loader_reset_c: cover property (loader_rst_set ##1 eeprom_load_done);
    channel_page_c: cover property (rd_en && page_sel_channel);

endmodule

/* File: test/rsrb_host_model.sv */
/*
 * Behavioural host that reaches the shared page through its strobe port.
 * Assumes ref_clk is the page clock; all changes land 1 ns after an edge.
 */
`timescale 1ns/1ps

module rsrb_host_model
    import rsrb_pkg::*;
(
    input wire logic ref_clk,
    output logic page_sel_channel,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] reg_addr,
    output logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    initial
    begin
        page_sel_channel = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        reg_addr = 8'h00;
        wr_data = 8'h00;
    end

    // ****************************************************************
    // access tasks
    // ****************************************************************
    task automatic set_page(input logic chan);
        @(posedge ref_clk);
        #1;
        page_sel_channel = chan;
    endtask

    // idle address and data show the inverse, never a stale match
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        #1;
        reg_addr = addr;
        wr_data = data;
        wr_en = 1'b1;
        @(posedge ref_clk);
        #1;
        wr_en = 1'b0;
        reg_addr = ~addr;
        wr_data = ~data;
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
        output logic valid);
        @(posedge ref_clk);
        #1;
        reg_addr = addr;
        rd_en = 1'b1;
        @(posedge ref_clk);
        #1;
        rd_en = 1'b0;
        reg_addr = ~addr;
        valid = rd_valid;
        data = rd_data;
    endtask

    // field update keeps every other bit as read
    task automatic modify_reg(input logic [7:0] addr, input logic [7:0] mask,
        input logic [7:0] val);
        logic [7:0] cur;
        logic ok;
        read_reg(addr, cur, ok);
        write_reg(addr, (cur & ~mask) | (val & mask));
    endtask
endmodule

/* File: test/rsrb_shared_page_test.sv */
/*
 * Self-checking bench for the shared register page.
 * Assumes the host model and the design files are compiled before it.
 */
`timescale 1ns/1ps

module rsrb_shared_page_test
    import rsrb_pkg::*;
;

    logic ref_clk;
    logic rst_b;
    logic page_sel_channel;
    logic wr_en;
    logic rd_en;
    logic [7:0] reg_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic rd_valid;
    logic [3:0] strap;
    logic eeld;
    logic [15:0] irq;
    logic [6:0] bus_target_addr;
    rsrb_ref_freq_t ref_sel;
    logic divclk;
    logic lockdis;
    logic [3:0] limit;
    logic crc;
    logic ldr_rst;
    int errors;
    int compares;
    logic [7:0] rdat;
    logic rv;
    // offsets 0 to 0x0A after reset, strap 5 and irq 0xA5C3
    logic [7:0] rst_val [0:10] = '{8'h50, 8'h2A, 8'h00, 8'h00, 8'h01,
        8'h18, 8'h00, 8'h00, 8'hC3, 8'hA5, 8'h00};

    rsrb_shared_page DUT (.ref_clk(ref_clk), .rst_b(rst_b),
        .page_sel_channel(page_sel_channel), .wr_en(wr_en), .rd_en(rd_en),
        .reg_addr(reg_addr), .wr_data(wr_data), .rd_data(rd_data),
        .rd_valid(rd_valid), .strap_address_bits(strap),
        .eeprom_load_done(eeld), .channel_irq_flag(irq),
        .bus_target_addr(bus_target_addr), .ref_frequency_choice(ref_sel),
        .divided_clock_out_choice(divclk), .lock_sequencer_disable(lockdis),
        .concurrent_lock_limit(limit), .crc_check_start(crc),
        .loader_controller_reset(ldr_rst));

    rsrb_host_model host (.ref_clk(ref_clk),
        .page_sel_channel(page_sel_channel), .wr_en(wr_en), .rd_en(rd_en),
        .reg_addr(reg_addr), .wr_data(wr_data), .rd_data(rd_data),
        .rd_valid(rd_valid));

    always #2 ref_clk = ~ref_clk;

    // ****************************************************************
    // checking
    // ****************************************************************
    task automatic chk(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        host.read_reg(addr, rdat, rv);
        chk("rd_valid", {15'h0, rv}, 16'h0001);
        chk($sformatf("offset %h", addr), {8'h00, rdat}, {8'h00, exp});
    endtask

    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask

    task automatic print_verdict();
        if (errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        #100000;
        errors++;
        print_verdict();
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial
    begin
        ref_clk = 1'b0;
        rst_b = 1'b0;
        strap = 4'h5;
        eeld = 1'b0;
        irq = 16'hA5C3;
        errors = 0;
        compares = 0;
        repeat (5) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        for (int i = 0; i < 11; i++)
            rd_chk(8'(i), rst_val[i]);
        chk("bus_target_addr", {9'h0, bus_target_addr}, 16'h001D);
        for (int c = 0; c < 3; c++)
        begin
            host.modify_reg(8'h02, 8'h60, 8'(c << 5));
            chk("ref_frequency_choice", {14'h0, ref_sel}, 16'(c));
            rd_chk(8'h02, 8'(c << 5));
        end
        host.write_reg(8'h02, 8'h60);
        chk("ref_frequency_choice", {14'h0, ref_sel}, 16'h0002);
        host.write_reg(8'h04, 8'h88);
        chk("divided_clock_out_choice", {15'h0, divclk}, 16'h0001);
        chk("lock_sequencer_disable", {15'h0, lockdis}, 16'h0001);
        rd_chk(8'h04, 8'h89);
        host.write_reg(8'h03, 8'hFF);
        rd_chk(8'h03, 8'h00);
        host.write_reg(8'h06, 8'hFF);
        rd_chk(8'h06, 8'h00);
        host.write_reg(8'h05, 8'h03);
        chk("concurrent_lock_limit", {12'h0, limit}, 16'h0003);
        host.write_reg(8'h05, 8'h43);
        chk("crc_check_start", {15'h0, crc}, 16'h0001);
        step();
        chk("crc_check_start", {15'h0, crc}, 16'h0000);
        rd_chk(8'h05, 8'h53);
        host.write_reg(8'h04, 8'hA8);
        chk("loader_controller_reset", {15'h0, ldr_rst}, 16'h0001);
        step();
        chk("loader_controller_reset", {15'h0, ldr_rst}, 16'h0000);
        rd_chk(8'h04, 8'h89);
        rd_chk(8'h05, 8'h43);
        eeld = 1'b1;
        step();
        eeld = 1'b0;
        rd_chk(8'h05, 8'h53);
        // loader reset and load done in one cycle: the set wins
        host.write_reg(8'h04, 8'hA8);
        eeld = 1'b1;
        step();
        eeld = 1'b0;
        rd_chk(8'h05, 8'h53);
        // page soft reset with other fields written in the same byte
        host.write_reg(8'h04, 8'hC8);
        step();
        chk("divided_clock_out_choice", {15'h0, divclk}, 16'h0000);
        chk("lock_sequencer_disable", {15'h0, lockdis}, 16'h0000);
        chk("concurrent_lock_limit", {12'h0, limit}, 16'h0008);
        chk("ref_frequency_choice", {14'h0, ref_sel}, 16'h0000);
        rd_chk(8'h04, 8'h01);
        rd_chk(8'h05, 8'h18);
        rd_chk(8'h00, 8'h50);
        // shared page closed while channel pages are selected
        host.set_page(1'b1);
        host.write_reg(8'h02, 8'h20);
        rd_chk(8'h00, 8'h00);
        chk("ref_frequency_choice", {14'h0, ref_sel}, 16'h0000);
        host.set_page(1'b0);
        rd_chk(8'h02, 8'h00);
        for (int i = 0; i < 16; i++)
        begin
            irq = 16'h0001 << i;
            rd_chk(8'h08, irq[7:0]);
            rd_chk(8'h09, irq[15:8]);
        end
        print_verdict();
    end
endmodule
